//--- design/ncp_nco_regs.sv
// Purpose: Channel A oscillator preset registers and phase path
// Assumes: Preset 2 phase word arrives from a sibling register bank
// Notes: Registers reached over AXI4-Lite; phase output is registered

`timescale 1ns/1ps
`default_nettype none

module ncp_nco_regs
    import ncp_pkg::*;
#(
    parameter int unsigned SAMPLE_DIV = 1
)
(
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [DATA_W-1:0] wdata,
    input wire logic [STRB_W-1:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [DATA_W-1:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic [PHASE_W-1:0] chanAPhasePreset2,
    output logic [ACC_W-1:0] phaseOut,
    output logic phaseValid
);

    // ****************************************
    // Helpers
    // ****************************************

    // Word-aligned compare; the two byte bits are ignored
    function automatic logic hitOfs(input logic [ADDR_W-1:0] a,
                                    input logic [ADDR_W-1:0] ofs);
        hitOfs = (a[ADDR_W-1:2] == ofs[ADDR_W-1:2]);
    endfunction

    // Byte-lane merge of a write into an old value
    function automatic logic [DATA_W-1:0] mergeStrb(
        input logic [DATA_W-1:0] old,
        input logic [DATA_W-1:0] wd,
        input logic [STRB_W-1:0] st);
        logic [DATA_W-1:0] res;
        res = old;
        for (int i = 0; i < STRB_W; i++)
        begin
            if (st[i])
                res[i*8 +: 8] = wd[i*8 +: 8];
        end
        mergeStrb = res;
    endfunction

    // ****************************************
    // Declarations
    // ****************************************
    logic wrEn;
    logic [ADDR_W-1:0] wrAddr;
    logic [DATA_W-1:0] wrData;
    logic [STRB_W-1:0] wrStrb;
    logic wrHit;
    logic [DATA_W-1:0] rdData;
    logic rdHit;
    logic [ACC_W-1:0] freqPre0_ff;
    logic [PHASE_W-1:0] phasePre0_ff;
    logic [ACC_W-1:0] freqPre1_ff;
    logic [PHASE_W-1:0] phasePre1_ff;
    logic [ACC_W-1:0] freqPre2_ff;
    logic [SEL_W-1:0] presetSel_ff;
    logic [RDIV_W-1:0] refDiv_ff;
    logic [ACC_W-1:0] activeFreq;
    logic [PHASE_W-1:0] activePhase;
    logic sampleEn;
    logic [ACC_W-1:0] accum;

    // ****************************************
    // Bus front end
    // ****************************************
    ncp_axil_slave u_bus (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .awaddr(awaddr),
        .awvalid(awvalid),
        .awready_ff(awready),
        .wdata(wdata),
        .wstrb(wstrb),
        .wvalid(wvalid),
        .wready_ff(wready),
        .bresp_ff(bresp),
        .bvalid_ff(bvalid),
        .bready(bready),
        .araddr(araddr),
        .arvalid(arvalid),
        .arready_ff(arready),
        .rdata_ff(rdata),
        .rresp_ff(rresp),
        .rvalid_ff(rvalid),
        .rready(rready),
        .wrEn(wrEn),
        .wrAddr(wrAddr),
        .wrData(wrData),
        .wrStrb(wrStrb),
        .wrHit(wrHit),
        .rdData(rdData),
        .rdHit(rdHit)
    );

    // Status is read-only, so a write to it is not a hit
    assign wrHit = hitOfs(wrAddr, OFS_FREQ0) || hitOfs(wrAddr, OFS_PHASE0)
                || hitOfs(wrAddr, OFS_FREQ1) || hitOfs(wrAddr, OFS_PHASE1)
                || hitOfs(wrAddr, OFS_FREQ2) || hitOfs(wrAddr, OFS_CTRL)
                || hitOfs(wrAddr, OFS_RDIV);

    // ****************************************
    // Preset registers
    // ****************************************

    // Frequency words, all reset to the same default
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            freqPre0_ff <= FREQ_RST;
            freqPre1_ff <= FREQ_RST;
            freqPre2_ff <= FREQ_RST;
        end
        else if (wrEn)
        begin
            if (hitOfs(wrAddr, OFS_FREQ0))
                freqPre0_ff <= mergeStrb(freqPre0_ff, wrData, wrStrb);
            if (hitOfs(wrAddr, OFS_FREQ1))
                freqPre1_ff <= mergeStrb(freqPre1_ff, wrData, wrStrb);
            if (hitOfs(wrAddr, OFS_FREQ2))
                freqPre2_ff <= mergeStrb(freqPre2_ff, wrData, wrStrb);
        end
    end

    // Phase words keep only the low half; upper lanes are dropped
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            phasePre0_ff <= PHASE_RST;
            phasePre1_ff <= PHASE_RST;
        end
        else if (wrEn)
        begin
            if (hitOfs(wrAddr, OFS_PHASE0))
                phasePre0_ff <= PHASE_W'(mergeStrb({PHASE_PAD, phasePre0_ff},
                    wrData, wrStrb));
            if (hitOfs(wrAddr, OFS_PHASE1))
                phasePre1_ff <= PHASE_W'(mergeStrb({PHASE_PAD, phasePre1_ff},
                    wrData, wrStrb));
        end
    end

    // Preset select and reference divisor
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            presetSel_ff <= SEL_RST;
            refDiv_ff <= RDIV_RST;
        end
        else if (wrEn)
        begin
            if (hitOfs(wrAddr, OFS_CTRL) && wrStrb[0])
                presetSel_ff <= wrData[SEL_LSB +: SEL_W];
            if (hitOfs(wrAddr, OFS_RDIV))
                refDiv_ff <= RDIV_W'(mergeStrb({16'h0000, refDiv_ff},
                    wrData, wrStrb));
        end
    end

    // ****************************************
    // Read-back
    // ****************************************

    // Narrow registers read with zeros above
    always_comb
    begin
        rdHit = 1'b1;
        rdData = '0;
        if (hitOfs(araddr, OFS_FREQ0))
            rdData = freqPre0_ff;
        else if (hitOfs(araddr, OFS_PHASE0))
            rdData = {PHASE_PAD, phasePre0_ff};
        else if (hitOfs(araddr, OFS_FREQ1))
            rdData = freqPre1_ff;
        else if (hitOfs(araddr, OFS_PHASE1))
            rdData = {PHASE_PAD, phasePre1_ff};
        else if (hitOfs(araddr, OFS_FREQ2))
            rdData = freqPre2_ff;
        else if (hitOfs(araddr, OFS_CTRL))
            rdData = {30'h0000_0000, presetSel_ff};
        else if (hitOfs(araddr, OFS_RDIV))
            rdData = {16'h0000, refDiv_ff};
        else if (hitOfs(araddr, OFS_STAT))
            rdData = accum;
        else
            rdHit = 1'b0;
    end

    // ****************************************
    // Oscillator
    // ****************************************

    // Code 3 has no preset here and falls back to preset 0
    always_comb
    begin
        case (presetSel_ff)
            2'h1:
            begin
                activeFreq = freqPre1_ff;
                activePhase = phasePre1_ff;
            end
            2'h2:
            begin
                activeFreq = freqPre2_ff;
                activePhase = chanAPhasePreset2;
            end
            default:
            begin
                activeFreq = freqPre0_ff;
                activePhase = phasePre0_ff;
            end
        endcase
    end

    // Fractional divisor correction lives elsewhere; plain sum here
    ncp_phase_acc #(
        .SAMPLE_DIV(SAMPLE_DIV)
    ) u_acc (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .freqWord(activeFreq),
        .phaseWord(activePhase),
        .sampleEn_ff(sampleEn),
        .accum_ff(accum),
        .phaseOut_ff(phaseOut),
        .phaseValid_ff(phaseValid)
    );

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!reset_n);

    logic [4:0] seenWr_ff;

    // Remembers which presets software has written since reset
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
            seenWr_ff <= 5'h00;
        else if (wrEn)
            seenWr_ff <= seenWr_ff | {hitOfs(wrAddr, OFS_FREQ2),
                hitOfs(wrAddr, OFS_PHASE1), hitOfs(wrAddr, OFS_FREQ1),
                hitOfs(wrAddr, OFS_PHASE0), hitOfs(wrAddr, OFS_FREQ0)};
    end

    freq0_reset_a: assert property (
        !seenWr_ff[0] |-> freqPre0_ff == FREQ_RST)
        else $error("preset 0 frequency left its default");
    phase0_write_a: assert property (
        wrEn && hitOfs(wrAddr, OFS_PHASE0) && wrStrb == 4'hF
        |=> phasePre0_ff == $past(wrData[15:0]) && bvalid)
        else $error("preset 0 phase write lost");
    phase_low_a: assert property (
        sampleEn |=> phaseOut[15:0] == $past(accum[15:0]))
        else $error("phase offset leaked below the top half");
    phase_add_a: assert property (
        sampleEn |=> phaseOut[31:16] ==
            16'($past(accum[31:16]) + $past(activePhase)))
        else $error("active phase not added to accumulator");
    quarter_turn_a: assert property (
        sampleEn && activePhase == 16'h4000
        |=> phaseOut - $past(accum) == 32'h4000_0000)
        else $error("phase step scale wrong");
    signed_wrap_a: assert property (
        sampleEn && activePhase[15]
        |=> phaseOut == $past(accum) - {16'(-$past(activePhase)), PHASE_PAD})
        else $error("negative phase does not wrap");
    freq1_reset_a: assert property (
        !seenWr_ff[2] |-> freqPre1_ff == FREQ_RST)
        else $error("preset 1 frequency left its default");
    phase1_reset_a: assert property (
        !seenWr_ff[3] |-> phasePre1_ff == PHASE_RST)
        else $error("preset 1 phase left its default");
    freq2_reset_a: assert property (
        !seenWr_ff[4] |-> freqPre2_ff == FREQ_RST)
        else $error("preset 2 frequency left its default");
    plain_acc_a: assert property (
        refDiv_ff == 16'h0000 && sampleEn ##SAMPLE_DIV sampleEn
        |=> accum == $past(accum, SAMPLE_DIV + 1)
            + $past(activeFreq, SAMPLE_DIV + 1) + $past(activeFreq))
        else $error("accumulator not plain with zero divisor");
    acc_step_a: assert property (
        sampleEn |=> accum == $past(accum) + $past(activeFreq))
        else $error("accumulator step wrong");

    write_seen_c: cover property (wrEn && wrHit);
    read_seen_c: cover property (arvalid && arready ##1 rvalid);
    preset_swap_c: cover property (presetSel_ff != $past(presetSel_ff));
    acc_wrap_c: cover property (sampleEn ##1 accum < $past(accum));

endmodule

`default_nettype wire

//--- common/ncp_pkg.sv
// Purpose: Shared constants for the channel A oscillator preset bank
// Assumes: 32-bit register bus, byte addresses as listed below
// Notes: One definition of every offset, reset value and field place

`default_nettype none

package ncp_pkg;

    // ****************************************
    // Bus geometry
    // ****************************************
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int STRB_W = 4;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ****************************************
    // Register offsets (byte addresses)
    // ****************************************
    localparam logic [ADDR_W-1:0] OFS_FREQ0 = 12'h220;
    localparam logic [ADDR_W-1:0] OFS_PHASE0 = 12'h224;
    localparam logic [ADDR_W-1:0] OFS_FREQ1 = 12'h228;
    localparam logic [ADDR_W-1:0] OFS_PHASE1 = 12'h22C;
    localparam logic [ADDR_W-1:0] OFS_FREQ2 = 12'h230;
    localparam logic [ADDR_W-1:0] OFS_CTRL = 12'h300;
    localparam logic [ADDR_W-1:0] OFS_RDIV = 12'h304;
    localparam logic [ADDR_W-1:0] OFS_STAT = 12'h308;

    // ****************************************
    // Field layout and reset values
    // ****************************************
    localparam int ACC_W = 32;
    localparam int PHASE_W = 16;
    localparam int RDIV_W = 16;
    localparam int SEL_W = 2;
    localparam int SEL_LSB = 0;
    localparam logic [ACC_W-1:0] FREQ_RST = 32'hC000_0000;
    localparam logic [PHASE_W-1:0] PHASE_RST = 16'h0000;
    localparam logic [RDIV_W-1:0] RDIV_RST = 16'h0000;
    localparam logic [SEL_W-1:0] SEL_RST = 2'h0;
    localparam logic [PHASE_W-1:0] PHASE_PAD = 16'h0000;

endpackage

`default_nettype wire

//--- design/ncp_phase_acc.sv
// Purpose: Phase accumulator with sample-rate enable and phase offset
// Assumes: Frequency and phase words come from same-clock registers
// Notes: Output phase lags the accumulator by one sample

`timescale 1ns/1ps
`default_nettype none

module ncp_phase_acc
    import ncp_pkg::*;
#(
    parameter int unsigned SAMPLE_DIV = 1
)
(
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic [ACC_W-1:0] freqWord,
    input wire logic [PHASE_W-1:0] phaseWord,
    output logic sampleEn_ff,
    output logic [ACC_W-1:0] accum_ff,
    output logic [ACC_W-1:0] phaseOut_ff,
    output logic phaseValid_ff
);

    logic [15:0] divCnt_ff;

    // Divider gives one enable pulse per sample period
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            divCnt_ff <= 16'h0000;
            sampleEn_ff <= 1'b0;
        end
        else if (divCnt_ff == 16'(SAMPLE_DIV - 1))
        begin
            divCnt_ff <= 16'h0000;
            sampleEn_ff <= 1'b1;
        end
        else
        begin
            divCnt_ff <= divCnt_ff + 16'h0001;
            sampleEn_ff <= 1'b0;
        end
    end

    // Accumulator wraps naturally at 2^32
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
            accum_ff <= '0;
        else if (sampleEn_ff)
            accum_ff <= accum_ff + freqWord;
    end

    // Offset sits in the top half; sign does not matter mod one turn
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            phaseOut_ff <= '0;
            phaseValid_ff <= 1'b0;
        end
        else
        begin
            phaseValid_ff <= sampleEn_ff;
            if (sampleEn_ff)
                phaseOut_ff <= accum_ff + {phaseWord, PHASE_PAD};
        end
    end

endmodule

`default_nettype wire

//--- design/ncp_axil_slave.sv
// Purpose: AXI4-Lite slave front end for the preset register bank
// Assumes: One write and one read in flight at most
// Notes: Decode is done by the parent through the hit inputs

`timescale 1ns/1ps
`default_nettype none

module ncp_axil_slave
    import ncp_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready_ff,
    input wire logic [DATA_W-1:0] wdata,
    input wire logic [STRB_W-1:0] wstrb,
    input wire logic wvalid,
    output logic wready_ff,
    output logic [1:0] bresp_ff,
    output logic bvalid_ff,
    input wire logic bready,
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready_ff,
    output logic [DATA_W-1:0] rdata_ff,
    output logic [1:0] rresp_ff,
    output logic rvalid_ff,
    input wire logic rready,
    output logic wrEn,
    output logic [ADDR_W-1:0] wrAddr,
    output logic [DATA_W-1:0] wrData,
    output logic [STRB_W-1:0] wrStrb,
    input wire logic wrHit,
    input wire logic [DATA_W-1:0] rdData,
    input wire logic rdHit
);

    logic awHeld_ff;
    logic wHeld_ff;
    logic [ADDR_W-1:0] awAddr_ff;
    logic [DATA_W-1:0] wData_ff;
    logic [STRB_W-1:0] wStrb_ff;

    // Write fires once both halves are held and no response is pending
    assign wrEn = awHeld_ff && wHeld_ff && !bvalid_ff;
    assign wrAddr = awAddr_ff;
    assign wrData = wData_ff;
    assign wrStrb = wStrb_ff;

    // Address channel: one address held until the write is done
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            awready_ff <= 1'b1;
            awHeld_ff <= 1'b0;
            awAddr_ff <= '0;
        end
        else if (awvalid && awready_ff)
        begin
            awready_ff <= 1'b0;
            awHeld_ff <= 1'b1;
            awAddr_ff <= awaddr;
        end
        else
        begin
            if (wrEn)
                awHeld_ff <= 1'b0;
            if (bvalid_ff && bready)
                awready_ff <= 1'b1;
        end
    end

    // Data channel, taken in either order with the address
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            wready_ff <= 1'b1;
            wHeld_ff <= 1'b0;
            wData_ff <= '0;
            wStrb_ff <= '0;
        end
        else if (wvalid && wready_ff)
        begin
            wready_ff <= 1'b0;
            wHeld_ff <= 1'b1;
            wData_ff <= wdata;
            wStrb_ff <= wstrb;
        end
        else
        begin
            if (wrEn)
                wHeld_ff <= 1'b0;
            if (bvalid_ff && bready)
                wready_ff <= 1'b1;
        end
    end

    // Response; unmapped or read-only targets answer SLVERR
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            bvalid_ff <= 1'b0;
            bresp_ff <= RESP_OKAY;
        end
        else if (wrEn)
        begin
            bvalid_ff <= 1'b1;
            bresp_ff <= wrHit ? RESP_OKAY : RESP_SLVERR;
        end
        else if (bvalid_ff && bready)
            bvalid_ff <= 1'b0;
    end

    // Read answers one cycle after the address is taken
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            arready_ff <= 1'b1;
            rvalid_ff <= 1'b0;
            rdata_ff <= '0;
            rresp_ff <= RESP_OKAY;
        end
        else if (arvalid && arready_ff)
        begin
            arready_ff <= 1'b0;
            rvalid_ff <= 1'b1;
            rdata_ff <= rdHit ? rdData : '0;
            rresp_ff <= rdHit ? RESP_OKAY : RESP_SLVERR;
        end
        else if (rvalid_ff && rready)
        begin
            rvalid_ff <= 1'b0;
            arready_ff <= 1'b1;
        end
    end

endmodule

`default_nettype wire

//--- tb/ncp_nco_regs_test.sv
// Purpose: Self-checking bench for the channel A oscillator preset bank
// Assumes: AXI4-Lite master driven here; one sample every two cycles
// Notes: Fixed seed for random words; bench functions give expectations

`timescale 1ns/1ps
`default_nettype none

module ncp_nco_regs_test
    import ncp_pkg::*;
;
    // ****************************************
    // Signals
    // ****************************************
    localparam int unsigned DIV = 2;
    localparam int LIMIT = 5000;
    localparam logic [ADDR_W-1:0] REG_ADDR [5] =
        '{OFS_FREQ0, OFS_PHASE0, OFS_FREQ1, OFS_PHASE1, OFS_FREQ2};
    logic refClk = 1'b0;
    logic resetN = 1'b0;
    logic [ADDR_W-1:0] awaddr = '0;
    logic awvalid = 1'b0;
    logic awready;
    logic [DATA_W-1:0] wdata = '0;
    logic [STRB_W-1:0] wstrb = '0;
    logic wvalid = 1'b0;
    logic wready;
    logic [1:0] bresp;
    logic bvalid;
    logic bready = 1'b0;
    logic [ADDR_W-1:0] araddr = '0;
    logic arvalid = 1'b0;
    logic arready;
    logic [DATA_W-1:0] rdata;
    logic [1:0] rresp;
    logic rvalid;
    logic rready = 1'b0;
    logic [PHASE_W-1:0] presetPhase2 = '0;
    logic [ACC_W-1:0] phaseOut;
    logic phaseValid;
    int nErrors = 0;
    int testsRun = 0;
    int cycles = 0;
    integer seed = 32'hee32;

    ncp_nco_regs #(.SAMPLE_DIV(DIV)) i_dut (
        .ref_clk(refClk), .reset_n(resetN),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .chanAPhasePreset2(presetPhase2),
        .phaseOut(phaseOut), .phaseValid(phaseValid)
    );

    // Free-running 25 MHz clock
    initial
    begin
        forever #20 refClk = ~refClk;
    end

    // ****************************************
    // Expectations, checks and bus tasks
    // ****************************************
    // Phase words keep only the low half; the upper half reads as zero
    function automatic logic [DATA_W-1:0] reg_mask(input int idx);
        return (idx == 1 || idx == 3) ? 32'h0000_FFFF : 32'hFFFF_FFFF;
    endfunction

    function automatic logic [DATA_W-1:0] reg_reset(input int idx);
        return (idx == 1 || idx == 3) ? 32'h0000_0000 : 32'hC000_0000;
    endfunction

    // Offset sits in the top half of the phase path, zeros below
    function automatic logic [ACC_W-1:0] justify(input logic [PHASE_W-1:0] p);
        return {p, 16'h0000};
    endfunction

    task automatic chk_data(input logic [DATA_W-1:0] got,
        input logic [DATA_W-1:0] exp, input string what);
        testsRun++;
        if (got !== exp)
        begin
            nErrors++;
            $display("mismatch at %0t: %s %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp,
        input string what);
        testsRun++;
        if (got !== exp)
        begin
            nErrors++;
            $display("mismatch at %0t: %s %h exp %h", $time, what, got, exp);
        end
    endtask

    // Address and data offered together; each dropped once it is taken
    task automatic axi_write(input logic [ADDR_W-1:0] a,
        input logic [DATA_W-1:0] d, input logic [STRB_W-1:0] s,
        output logic [1:0] r);
        @(posedge refClk);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do
        begin
            @(posedge refClk);
            if (awready === 1'b1)
                awvalid <= 1'b0;
            if (wready === 1'b1)
                wvalid <= 1'b0;
        end
        while (bvalid !== 1'b1);
        r = bresp;
        bready <= 1'b0;
    endtask

    task automatic axi_read(input logic [ADDR_W-1:0] a,
        output logic [DATA_W-1:0] d, output logic [1:0] r);
        @(posedge refClk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do
        begin
            @(posedge refClk);
            if (arready === 1'b1)
                arvalid <= 1'b0;
        end
        while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask

    // Preset 2 offset comes from the sibling bank, so it is a plain input
    task automatic set_phase(input int s, input logic [PHASE_W-1:0] p);
        logic [1:0] r;
        if (s == 2)
            presetPhase2 <= p;
        else
        begin
            axi_write(REG_ADDR[2*s+1], {16'h0000, p}, 4'hF, r);
            chk_resp(r, RESP_OKAY, "phase write");
        end
    endtask

    task automatic next_phase(output logic [ACC_W-1:0] p);
        do
            @(posedge refClk);
        while (phaseValid !== 1'b1);
        p = phaseOut;
    endtask

    task automatic results();
        $display("comparisons %0d mismatches %0d", testsRun, nErrors);
        if (nErrors == 0 && testsRun > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // Cycle ceiling, far above the few hundred cycles the sequence needs
    always @(posedge refClk)
    begin
        cycles <= cycles + 1;
        if (cycles == LIMIT)
        begin
            nErrors++;
            $display("mismatch at %0t: timeout", $time);
            results();
        end
    end

    // ****************************************
    // Sequence
    // ****************************************
    initial
    begin
        logic [DATA_W-1:0] d;
        logic [DATA_W-1:0] wd [5];
        logic [1:0] r;
        logic [ACC_W-1:0] x1;
        logic [ACC_W-1:0] x2;
        logic [ACC_W-1:0] f;
        logic [PHASE_W-1:0] p2;
        logic [PHASE_W-1:0] p1;
        repeat (2) @(posedge refClk);
        resetN <= 1'b1;
        for (int i = 0; i < 5; i++)
        begin
            axi_read(REG_ADDR[i], d, r);
            f = reg_reset(i);
            chk_data(d, f, "reset");
        end
        $display("test reset values done");
        // All-ones corner first, then random words, written back to back
        for (int k = 0; k < 4; k++)
        begin
            for (int i = 0; i < 5; i++)
            begin
                wd[i] = (k == 0) ? 32'hFFFF_FFFF : $random(seed);
                axi_write(REG_ADDR[i], wd[i], 4'hF, r);
                chk_resp(r, RESP_OKAY, "write resp");
            end
            for (int i = 0; i < 5; i++)
            begin
                axi_read(REG_ADDR[i], d, r);
                f = wd[i] & reg_mask(i);
                chk_data(d, f, "readback");
            end
        end
        // One byte lane only: the other three keep their old contents
        d = $random(seed);
        axi_write(OFS_FREQ1, d, 4'h4, r);
        f = (wd[2] & 32'hFF00_FFFF) | (d & 32'h00FF_0000);
        axi_read(OFS_FREQ1, d, r);
        chk_data(d, f, "byte lane");
        $display("test readback done");
        // Unmapped place and the read-only status word refuse writes
        axi_write(12'h3FC, 32'h1234_5678, 4'hF, r);
        chk_resp(r, RESP_SLVERR, "unmapped write");
        axi_read(12'h3FC, d, r);
        chk_resp(r, RESP_SLVERR, "unmapped read");
        chk_data(d, 32'h0000_0000, "unmapped data");
        axi_write(OFS_STAT, 32'h0000_0001, 4'hF, r);
        chk_resp(r, RESP_SLVERR, "status write");
        // Divisor keeps its low half; put back to zero for the plain path
        axi_write(OFS_RDIV, 32'hFFFF_FFFF, 4'hF, r);
        axi_read(OFS_RDIV, d, r);
        chk_data(d, 32'h0000_FFFF, "divisor");
        axi_write(OFS_RDIV, 32'h0000_0000, 4'hF, r);
        chk_resp(r, RESP_OKAY, "divisor write");
        $display("test refusals done");
        // Each preset in turn: step size, then offset with a still accumulator
        for (int s = 0; s < 3; s++)
        begin
            f = $random(seed);
            axi_write(REG_ADDR[2*s], f, 4'hF, r);
            axi_write(OFS_CTRL, DATA_W'(s), 4'hF, r);
            repeat (3) next_phase(x1);
            next_phase(x2);
            chk_data(x2 - x1, f, "phase step");
            axi_write(REG_ADDR[2*s], 32'h0000_0000, 4'hF, r);
            // Preset 1 starts from a quarter turn, the others from -1 step
            p1 = (s == 1) ? 16'h4000 : 16'hFFFF;
            set_phase(s, p1);
            repeat (3) next_phase(x1);
            p2 = 16'($random(seed));
            set_phase(s, p2);
            repeat (3) next_phase(x2);
            f = justify(p2) - justify(p1);
            chk_data(x2 - x1, f, "offset");
        end
        $display("test oscillator done");
        results();
    end
endmodule

`default_nettype wire
